// ### design/acp_consts.vh
// Constants for the converter control and input pairing block
`ifndef ACP_CONSTS_VH
`define ACP_CONSTS_VH
// Register byte addresses (printed offsets are not all multiples of four)
`define ACP_IDX_PAIR_CFG    8'hba
`define ACP_IDX_CONV_CTRL   8'he8
`define ACP_ADDR_PAIR_CFG   12'h2e8
`define ACP_ADDR_CONV_CTRL  12'h3a0
`define ACP_ADDR_RESULT     12'h400
`define ACP_ADDR_IRQ_STAT   12'h404
`define ACP_ADDR_IRQ_MASK   12'h408
// Control register fields
`define ACP_BIT_ENABLE      7
`define ACP_BIT_TRACK_MODE  6
`define ACP_BIT_DONE        5
`define ACP_BIT_BUSY        4
`define ACP_BIT_TRIG_HI     3
`define ACP_BIT_TRIG_LO     2
`define ACP_BIT_WINDOW      1
`define ACP_BIT_JUSTIFY     0
// Reset values
`define ACP_RST_PAIR_CFG    8'h00
`define ACP_RST_CONV_CTRL   8'h00
`define ACP_PAIR_CFG_MASK   8'h0f
// Start trigger codes
`define ACP_TRIG_SOFTWARE   2'h0
`define ACP_TRIG_TIMER3     2'h1
`define ACP_TRIG_PIN        2'h2
`define ACP_TRIG_TIMER2     2'h3
// Timing
`define ACP_TRACK_SAR_CLKS  4'h3
`define ACP_CONV_SAR_CLKS   5'h0b
`define ACP_SAR_DIV         4'h4
// Interrupt status bits
`define ACP_IRQ_DONE        0
`define ACP_IRQ_BUSY_FALL   1
`endif

// ### design/acp_converter_ctrl.v
// Converter control, input pairing registers and AXI4-Lite slave
//
// Contract
// - Enable low holds converter in shutdown
// - Track mode zero: track except while converting
// - Track mode one: track three SAR clocks
// - Done flag set by hardware, software clears
// - Busy reads one during conversion, fall interrupts
// - Busy write one starts; zero ignored
// - Justify bit selects right or left result
// - Pair bit makes even/odd differential pair
// - Upper pair config bits read zero
// - Differential right-justified result is two's complement; left-justified drops the sign
`timescale 1ns/1ps
`include "acp_consts.vh"
module acp_converter_ctrl (
  input  wire        clk_sys_in,        // System clock, 50 MHz
  input  wire        rst_in,            // Async reset, active high
  input  wire [11:0] s_axi_awaddr,      // Write address
  input  wire        s_axi_awvalid,     // Write address valid
  output reg         s_axi_awready,     // Write address ready
  input  wire [31:0] s_axi_wdata,       // Write data
  input  wire [3:0]  s_axi_wstrb,       // Write strobes
  input  wire        s_axi_wvalid,      // Write data valid
  output reg         s_axi_wready,      // Write data ready
  output reg  [1:0]  s_axi_bresp,       // Write response
  output reg         s_axi_bvalid,      // Write response valid
  input  wire        s_axi_bready,      // Write response ready
  input  wire [11:0] s_axi_araddr,      // Read address
  input  wire        s_axi_arvalid,     // Read address valid
  output reg         s_axi_arready,     // Read address ready
  output reg  [31:0] s_axi_rdata,       // Read data
  output reg  [1:0]  s_axi_rresp,       // Read response
  output reg         s_axi_rvalid,      // Read data valid
  input  wire        s_axi_rready,      // Read data ready
  input  wire        timer3_ovf_in,     // Timer 3 overflow pulse
  input  wire        timer2_ovf_in,     // Timer 2 overflow pulse
  input  wire        ext_start_in,      // External start pin, async
  input  wire [9:0]  sar_data_in,       // Raw code from analog front end
  input  wire        sar_sign_in,       // Negative differential result
  output reg         conv_power_out,    // Converter powered
  output reg         conv_track_out,    // Front end tracking
  output reg         conv_convert_out,  // Front end converting
  output reg         sar_clk_en_out,    // SAR clock enable pulse
  output reg  [3:0]  pair_diff_out,     // Pair differential selects
  output reg  [15:0] result_out,        // Justified result word
  output reg         irq_out            // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV  = 2'h2;

  reg  [7:0]  pair_cfg_q;
  reg         enable_q;
  reg         track_mode_q;
  reg         done_q;
  reg         window_q;
  reg  [1:0]  trig_q;
  reg         justify_q;
  reg  [1:0]  state_q;
  reg  [4:0]  sar_cnt_q;
  reg  [3:0]  div_q;
  reg         pin_meta_q;
  reg         pin_sync_q;
  reg         pin_prev_q;
  reg  [15:0] result_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_mask_q;
  reg  [11:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg         busy_prev_q;

  wire busy = (state_q != ST_IDLE);
  wire sar_tick = (div_q == `ACP_SAR_DIV - 4'h1);
  // Abort by disable also counts as a busy fall
  wire busy_fall = busy_prev_q && !busy;

  // Justify and sign-extend the raw code
  function [15:0] justify_word;
    input [9:0] code;
    input       neg;
    input       diff;
    input       left;
    reg   [10:0] val;
    begin
      val = diff ? {neg, code} : {1'b0, code};
      if (left)
        justify_word = {code, 6'h00};
      else if (diff)
        justify_word = {{5{val[10]}}, val};
      else
        justify_word = {6'h00, code};
    end
  endfunction

  // Word address of a byte address; low two bits ignored
  function [11:0] word_addr;
    input [11:0] a;
    begin
      word_addr = {a[11:2], 2'b00};
    end
  endfunction

  // Address hits one of the five registers
  function reg_known;
    input [11:0] a;
    begin
      reg_known = (word_addr(a) == `ACP_ADDR_CONV_CTRL) ||
                  (word_addr(a) == `ACP_ADDR_PAIR_CFG) ||
                  (word_addr(a) == `ACP_ADDR_RESULT) ||
                  (word_addr(a) == `ACP_ADDR_IRQ_STAT) ||
                  (word_addr(a) == `ACP_ADDR_IRQ_MASK);
    end
  endfunction

  // Last SAR tick of a phase of the given length
  function last_tick;
    input [4:0] cnt;
    input [4:0] len;
    begin
      last_tick = (cnt == len - 5'h01);
    end
  endfunction

  // Pin start mode pauses tracking while the pin is high
  function track_allowed;
    input [1:0] trig;
    input       pin;
    begin
      track_allowed = !(trig == `ACP_TRIG_PIN && pin);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data taken in either order
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (awaddr_q == `ACP_ADDR_CONV_CTRL) && wstrb_q[0];
  wire wr_pair = wr_go && (awaddr_q == `ACP_ADDR_PAIR_CFG) && wstrb_q[0];
  wire wr_stat = wr_go && (awaddr_q == `ACP_ADDR_IRQ_STAT) && wstrb_q[0];
  wire wr_mask = wr_go && (awaddr_q == `ACP_ADDR_IRQ_MASK) && wstrb_q[0];
  wire wr_known = reg_known(awaddr_q);

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= word_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start source selection
  wire pin_rise = pin_sync_q && !pin_prev_q;
  wire sw_start = wr_ctrl && wdata_q[`ACP_BIT_BUSY];
  reg  start_evt;
  always @* begin
    case (trig_q)
      `ACP_TRIG_SOFTWARE: start_evt = sw_start;
      `ACP_TRIG_TIMER3:   start_evt = timer3_ovf_in;
      `ACP_TRIG_PIN:      start_evt = pin_rise;
      `ACP_TRIG_TIMER2:   start_evt = timer2_ovf_in;
      default:            start_evt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and conversion sequencer
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pair_cfg_q   <= `ACP_RST_PAIR_CFG;
      enable_q     <= 1'b0;
      track_mode_q <= 1'b0;
      done_q       <= 1'b0;
      window_q     <= 1'b0;
      trig_q       <= 2'h0;
      justify_q    <= 1'b0;
      state_q      <= ST_IDLE;
      sar_cnt_q    <= 5'h00;
      div_q        <= 4'h0;
      pin_meta_q   <= 1'b0;
      pin_sync_q   <= 1'b0;
      pin_prev_q   <= 1'b0;
      busy_prev_q  <= 1'b0;
      result_q     <= 16'h0000;
      irq_stat_q   <= 2'h0;
      irq_mask_q   <= 2'h0;
    end else begin
      pin_meta_q <= ext_start_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      busy_prev_q <= busy;
      div_q <= sar_tick ? 4'h0 : div_q + 4'h1;
      if (wr_pair)
        pair_cfg_q <= wdata_q[7:0] & `ACP_PAIR_CFG_MASK;
      if (wr_ctrl) begin
        enable_q     <= wdata_q[`ACP_BIT_ENABLE];
        track_mode_q <= wdata_q[`ACP_BIT_TRACK_MODE];
        done_q       <= wdata_q[`ACP_BIT_DONE];
        window_q     <= wdata_q[`ACP_BIT_WINDOW];
        trig_q       <= wdata_q[`ACP_BIT_TRIG_HI:`ACP_BIT_TRIG_LO];
        justify_q    <= wdata_q[`ACP_BIT_JUSTIFY];
      end
      if (wr_mask)
        irq_mask_q <= wdata_q[1:0];
      if (wr_stat)
        irq_stat_q <= irq_stat_q & ~wdata_q[1:0];
      case (state_q)
        ST_IDLE: begin
          // Shutdown ignores start events
          if (enable_q && start_evt) begin
            sar_cnt_q <= 5'h00;
            if (track_mode_q)
              state_q <= ST_TRACK;
            else
              state_q <= ST_CONV;
          end
        end
        ST_TRACK: begin
          // Pin mode tracks only while the pin is low
          if (sar_tick && track_allowed(trig_q, pin_sync_q)) begin
            if (last_tick(sar_cnt_q, {1'b0, `ACP_TRACK_SAR_CLKS})) begin
              sar_cnt_q <= 5'h00;
              state_q   <= ST_CONV;
            end else begin
              sar_cnt_q <= sar_cnt_q + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (sar_tick) begin
            if (last_tick(sar_cnt_q, `ACP_CONV_SAR_CLKS)) begin
              state_q <= ST_IDLE;
              done_q  <= 1'b1;
              irq_stat_q[`ACP_IRQ_DONE] <= 1'b1;
              result_q <= justify_word(sar_data_in, sar_sign_in,
                                       pair_diff_out != 4'h0,
                                       justify_q);
            end else begin
              sar_cnt_q <= sar_cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (busy_fall)
        irq_stat_q[`ACP_IRQ_BUSY_FALL] <= 1'b1;
      if (!enable_q)
        state_q <= ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front-end outputs, all registered
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      conv_power_out   <= 1'b0;
      conv_track_out   <= 1'b0;
      conv_convert_out <= 1'b0;
      sar_clk_en_out   <= 1'b0;
      pair_diff_out    <= 4'h0;
      result_out       <= 16'h0000;
      irq_out          <= 1'b0;
    end else begin
      conv_power_out   <= enable_q;
      conv_track_out   <= enable_q && (track_mode_q ?
                          (state_q == ST_TRACK &&
                           track_allowed(trig_q, pin_sync_q)) :
                          !busy);
      conv_convert_out <= (state_q == ST_CONV);
      sar_clk_en_out   <= sar_tick;
      pair_diff_out    <= pair_cfg_q[3:0];
      result_out       <= result_q;
      irq_out          <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  reg [31:0] rd_word;
  always @* begin
    case (word_addr(s_axi_araddr))
      `ACP_ADDR_PAIR_CFG:
        rd_word = {24'h000000, pair_cfg_q};
      `ACP_ADDR_CONV_CTRL:
        rd_word = {24'h000000, enable_q, track_mode_q, done_q, busy,
                   trig_q, window_q, justify_q};
      `ACP_ADDR_RESULT:  rd_word = {16'h0000, result_q};
      `ACP_ADDR_IRQ_STAT: rd_word = {30'h00000000, irq_stat_q};
      `ACP_ADDR_IRQ_MASK: rd_word = {30'h00000000, irq_mask_q};
      default:           rd_word = 32'h00000000;
    endcase
  end

  wire rd_known = reg_known(s_axi_araddr);

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // acp_converter_ctrl

// ### sim/acp_converter_ctrl_sva.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module acp_converter_ctrl_sva (
  input wire        clk_sys_in,       // System clock
  input wire        rst_in,           // Async reset
  input wire        s_axi_bvalid,     // Write response valid
  input wire        s_axi_bready,     // Write response ready
  input wire        s_axi_rvalid,     // Read data valid
  input wire        s_axi_rready,     // Read data ready
  input wire [31:0] s_axi_rdata,      // Read data
  input wire        conv_power_out,   // Converter powered
  input wire        conv_track_out,   // Tracking
  input wire        conv_convert_out, // Converting
  input wire        sar_clk_en_out    // SAR tick
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [7:0] cnt_q;
  always @(posedge clk_sys_in or posedge rst_in)
    if (rst_in) cnt_q <= 8'h00;
    else cnt_q <= conv_convert_out ? cnt_q + 8'h01 : 8'h00;
  sequence tick_gap; !sar_clk_en_out [*3]; endsequence
  sequence conv_end; $fell(conv_convert_out) && conv_power_out; endsequence
  ////////////////////////////////////////
  a_shutdown_quiet: assert property (!conv_power_out &&
    !$past(conv_power_out) && !$past(conv_power_out, 2)
    |-> !conv_track_out && !conv_convert_out) else $error("Active when off");
  a_track_conv_excl: assert property (
    !(conv_track_out && conv_convert_out)) else $error("Track overlap");
  a_conv_after_track: assert property (
    $rose(conv_convert_out) |-> $past(conv_track_out))
    else $error("Conversion without tracking");
  a_sar_tick_gap: assert property (
    sar_clk_en_out && conv_power_out |=> tick_gap)
    else $error("SAR tick spacing");
  a_conv_length: assert property (conv_end |->
    cnt_q >= 8'h29 && cnt_q <= 8'h2f) else $error("Conversion length");
  a_read_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("Upper read bits set");
  a_bresp_closes: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  a_rresp_closes: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read response repeated");
endmodule // acp_converter_ctrl_sva
bind acp_converter_ctrl acp_converter_ctrl_sva u_sva (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .conv_power_out(conv_power_out),
  .conv_track_out(conv_track_out), .conv_convert_out(conv_convert_out),
  .sar_clk_en_out(sar_clk_en_out));

// ### sim/acp_front_end_model.sv
// Behavioural analog front end answering the converter control block
`timescale 1ns/1ps
module acp_front_end_model (
  input  wire        clk_sys_in,      // System clock
  input  wire        conv_convert_in, // Block is converting
  input  wire [3:0]  pair_diff_in,    // Pair differential selects
  output logic [9:0] sar_data_out,    // Raw code to the block
  output logic       sar_sign_out     // Negative differential result
);
  logic       cv_q   = 1'b0;
  logic [9:0] junk_q = 10'h000;
  always @(posedge clk_sys_in) begin
    cv_q   <= conv_convert_in;
    junk_q <= ~junk_q ^ 10'h0f0;
  end
  // Code valid while converting and one cycle after, toggles otherwise
  wire vld = conv_convert_in | cv_q;
  assign sar_data_out = vld ? 10'h155 : junk_q;
  assign sar_sign_out = vld ? |pair_diff_in : junk_q[0];
endmodule // acp_front_end_model

// ### sim/adc_control_and_input_pairing_bench.sv
// Register-level bench for the converter control block
`timescale 1ns/1ps
`include "acp_consts.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module adc_control_and_input_pairing_bench;
  logic clk_sys_in = '0, rst_in = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, ctl;
  logic [3:0]  s_axi_wstrb = 4'hf, pair_diff_out;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, timer3_ovf_in = '0;
  logic timer2_ovf_in = '0, ext_start_in = '0, sar_sign_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_power_out, conv_track_out, irq_out;
  logic conv_convert_out, sar_clk_en_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [9:0]  sar_data_in;
  logic [15:0] result_out;
  int errors = 0, tests_run = 0;
  acp_converter_ctrl u_acp_converter_ctrl (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer3_ovf_in(timer3_ovf_in), .timer2_ovf_in(timer2_ovf_in),
    .ext_start_in(ext_start_in), .sar_data_in(sar_data_in),
    .sar_sign_in(sar_sign_in), .conv_power_out(conv_power_out),
    .conv_track_out(conv_track_out),
    .conv_convert_out(conv_convert_out),
    .sar_clk_en_out(sar_clk_en_out), .pair_diff_out(pair_diff_out),
    .result_out(result_out), .irq_out(irq_out));
  acp_front_end_model u_acp_front_end_model (.clk_sys_in(clk_sys_in),
    .conv_convert_in(conv_convert_out), .pair_diff_in(pair_diff_out),
    .sar_data_out(sar_data_in), .sar_sign_out(sar_sign_in));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////
  task automatic wr32(input [11:0] a, input [31:0] d, output [1:0] r);
    @(posedge clk_sys_in);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0; s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
  endtask
  task automatic rd32(input [11:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk_sys_in);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0; s_axi_arvalid <= 1'b0;
  endtask
  task automatic rc(input [11:0] a, input [31:0] e, input string n);
    rd32(a, rd, resp);
    `CHK(n, e, rd)
  endtask
  // Polls busy; bounded so a stuck busy falls through to the checks
  task automatic idle;
    int k;
    k = 0;
    do begin rd32(`ACP_ADDR_CONV_CTRL, rd, resp); k++; end
    while (rd[`ACP_BIT_BUSY] && k < 200);
  endtask
  // Pin pulse passes a two-flop synchroniser, hence the settle cycles
  task automatic fire(input int c);
    @(posedge clk_sys_in);
    timer3_ovf_in <= (c == 1); ext_start_in <= (c == 2);
    timer2_ovf_in <= (c == 3);
    @(posedge clk_sys_in);
    timer3_ovf_in <= 1'b0; ext_start_in <= 1'b0; timer2_ovf_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task end_of_test;
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rc(`ACP_ADDR_CONV_CTRL, 32'h0, "ctrl_rst");
    rc(`ACP_ADDR_PAIR_CFG, 32'h0, "pair_rst");
    wr32(`ACP_ADDR_PAIR_CFG, 32'hff, resp);
    rc(`ACP_ADDR_PAIR_CFG, 32'h0f, "pair_hi");
    `CHK("pair_out", 4'hf, pair_diff_out)
    wr32(12'h0f0, 32'h1, resp);
    `CHK("bresp", 2'h3, resp)
    rd32(12'h0f0, rd, resp);
    `CHK("rresp", 2'h3, resp)
    wr32(`ACP_ADDR_CONV_CTRL, 32'h10, resp);
    rc(`ACP_ADDR_CONV_CTRL, 32'h0, "off_start");
    `CHK("power_off", 1'b0, conv_power_out)
    wr32(`ACP_ADDR_CONV_CTRL, 32'h80, resp);
    rc(`ACP_ADDR_CONV_CTRL, 32'h80, "busy_w0");
    `CHK("power_on", 1'b1, conv_power_out)
    `CHK("track_on", 1'b1, conv_track_out)
    wr32(`ACP_ADDR_CONV_CTRL, 32'h90, resp);
    rc(`ACP_ADDR_CONV_CTRL, 32'h90, "busy_run");
    `CHK("track_conv", 1'b0, conv_track_out)
    idle;
    rc(`ACP_ADDR_CONV_CTRL, 32'ha0, "done_set");
    rc(`ACP_ADDR_RESULT, 32'hfd55, "res_diff");
    `CHK("res_out_diff", 16'hfd55, result_out)
    rc(`ACP_ADDR_IRQ_STAT, 32'h3, "irq_stat");
    `CHK("irq_masked", 1'b0, irq_out)
    wr32(`ACP_ADDR_IRQ_MASK, 32'h2, resp);
    rc(`ACP_ADDR_IRQ_MASK, 32'h2, "mask");
    `CHK("irq_on", 1'b1, irq_out)
    wr32(`ACP_ADDR_IRQ_STAT, 32'h3, resp);
    rc(`ACP_ADDR_CONV_CTRL, 32'ha0, "done_keep");
    `CHK("irq_clr", 1'b0, irq_out)
    wr32(`ACP_ADDR_PAIR_CFG, 32'h0, resp);
    wr32(`ACP_ADDR_CONV_CTRL, 32'h91, resp);
    idle;
    rc(`ACP_ADDR_RESULT, 32'h5540, "res_left");
    `CHK("res_out_left", 16'h5540, result_out)
    `CHK("irq_fall", 1'b1, irq_out)
    wr32(`ACP_ADDR_CONV_CTRL, 32'h80, resp);
    rc(`ACP_ADDR_CONV_CTRL, 32'h80, "done_clr");
    for (int c = 1; c < 4; c++) begin
      ctl = 32'hc0 | (c << 2);
      wr32(`ACP_ADDR_CONV_CTRL, ctl, resp);
      fire(c % 3 + 1);
      rc(`ACP_ADDR_CONV_CTRL, ctl, "no_start");
      `CHK("track_idle", 1'b0, conv_track_out)
      fire(c);
      rc(`ACP_ADDR_CONV_CTRL, ctl | 32'h10, "trig_busy");
      idle;
      rc(`ACP_ADDR_CONV_CTRL, ctl | 32'h20, "trig_done");
    end
    end_of_test;
  end
endmodule // adc_control_and_input_pairing_bench
